// file: hdl/sup_pkg.sv
/*
  Constants and types shared by the supervision timer files.
  Assumes an 8-bit special function register space on the core clock.
*/
package sup_pkg;

  // Register offsets in the special function register space
  localparam logic [7:0] SERVICE_KEY_ADDR = 8'ha6;
  localparam logic [7:0] TIMEOUT_PROG_ADDR = 8'ha7;

  // Key byte sequence
  localparam logic [7:0] KEY_FIRST = 8'h1e;
  localparam logic [7:0] KEY_SECOND = 8'he1;

  // Timeout program register layout
  localparam int TSEL_LSB = 0;
  localparam int TSEL_W = 3;
  localparam logic [2:0] TSEL_RESET = 3'h0;
  localparam int PROG_RSVD_LSB = 3;
  localparam logic [4:0] PROG_RSVD_READ = 5'h00;

  // Count chain
  localparam int PRESCALER_W = 14;
  localparam int COUNTER_W = 7;
  localparam int CHAIN_W = PRESCALER_W + COUNTER_W;
  localparam int PHASE_DIV = 6;
  localparam logic [2:0] PHASE_LAST = 3'h5;

  // Reset pin pulse, in oscillator periods; core_clk is the oscillator
  localparam int RST_PULSE_OSC = 96;
  localparam int RST_PULSE_CYCLES = RST_PULSE_OSC;
  localparam logic [6:0] RST_PULSE_LAST = 7'(RST_PULSE_CYCLES - 1);

  typedef enum logic [0:0] {
    KEY_WAIT_FIRST,
    KEY_WAIT_SECOND
  } sup_key_t;

  typedef enum logic [1:0] {
    TMR_DISABLED,
    TMR_RUNNING,
    TMR_RST_PULSE
  } sup_state_t;

endpackage

// file: hdl/sup_count_chain.sv
/*
  Six-phase stage, 14-bit prescaler and 7-bit programmable counter.
  Assumes tick is a one-cycle enable at the supervision clock rate.
*/
module sup_count_chain
  import sup_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic [sup_pkg::TSEL_W-1:0] timeoutSel,
  // State
  output logic terminal,
  output logic [sup_pkg::PRESCALER_W-1:0] prescalerVal,
  output logic [sup_pkg::COUNTER_W-1:0] counterVal
);

  logic [2:0] phase_ff;
  logic [2:0] nxt_phase;
  logic [CHAIN_W-1:0] chain_ff;
  logic [CHAIN_W-1:0] nxt_chain;
  logic [CHAIN_W-1:0] lastVal;

  // Overflow at the end of 2^(14+n)-1 whole phase rounds
  function automatic logic [CHAIN_W-1:0] sup_last(input logic [TSEL_W-1:0] sel);
    logic [CHAIN_W:0] full;
    full = (CHAIN_W+1)'(1) << (PRESCALER_W + int'(sel));
    return CHAIN_W'(full - (CHAIN_W+1)'(2));
  endfunction

  assign lastVal = sup_last(timeoutSel);
  assign terminal = tick && !clear && (phase_ff == PHASE_LAST) && (chain_ff == lastVal);
  assign prescalerVal = chain_ff[PRESCALER_W-1:0];
  assign counterVal = chain_ff[CHAIN_W-1:PRESCALER_W];

  always_comb begin
    nxt_phase = phase_ff;
    nxt_chain = chain_ff;
    if (clear) begin
      nxt_phase = 3'h0;
      nxt_chain = '0;
    end else if (tick) begin
      if (phase_ff == PHASE_LAST) begin
        nxt_phase = 3'h0;
        nxt_chain = chain_ff + CHAIN_W'(1);
      end else begin
        nxt_phase = phase_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_ff <= 3'h0;
      chain_ff <= '0;
    end else begin
      phase_ff <= nxt_phase;
      chain_ff <= nxt_chain;
    end
  end

endmodule

// file: hdl/sup_supervision_timer.sv
/*
  Supervision timer: key detection on the service register, timeout
  program register, supervision clock selection, count chain and the
  reset pin pulse on overflow.
  Assumes the core presents special function register accesses as
  one-cycle strobes on core_clk, and that rst is the chip reset.
*/
module sup_supervision_timer
  import sup_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Special function register access
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  output logic sfrHit,
  // Clock and power mode
  input wire logic doubleSpeedMode,
  input wire logic fixedClockSelect,
  input wire logic idleMode,
  input wire logic powerDown,
  // Reset pin
  output logic rstPinOut,
  output logic rstPinOeN,
  // Status
  output logic timerEnabled,
  output logic [sup_pkg::COUNTER_W-1:0] counterValue
);

  // Decoded bus accesses
  logic keyWrite;
  logic progWrite;
  logic progRead;

  // Key recognition
  sup_key_t key_ff;
  sup_key_t nxt_key;
  logic keyDone;

  // Timeout program register
  logic [TSEL_W-1:0] tsel_ff;
  logic [TSEL_W-1:0] nxt_tsel;

  // Supervision clock
  logic half_ff;
  logic nxt_half;
  logic superTick;

  // Timer control
  sup_state_t state_ff;
  sup_state_t nxt_state;
  logic [6:0] pulse_ff;
  logic [6:0] nxt_pulse;
  logic chainClear;
  logic chainTick;
  logic overflow;
  logic enabled_ff;
  logic nxt_enabled;

  // Outputs from flip-flops
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic pin_ff;
  logic nxt_pin;

  logic [PRESCALER_W-1:0] prescalerVal;
  logic [COUNTER_W-1:0] counterVal;

  // Register select, shared by strobes and hit
  function automatic logic sup_hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  assign keyWrite = sfrWr && sup_hit(sfrAddr, SERVICE_KEY_ADDR);
  assign progWrite = sfrWr && sup_hit(sfrAddr, TIMEOUT_PROG_ADDR);
  assign progRead = sfrRd && sup_hit(sfrAddr, TIMEOUT_PROG_ADDR);
  assign sfrHit = sup_hit(sfrAddr, SERVICE_KEY_ADDR) || sup_hit(sfrAddr, TIMEOUT_PROG_ADDR);

  // Key pair detector
  always_comb begin
    nxt_key = key_ff;
    keyDone = 1'b0;
    if (keyWrite) begin
      case (key_ff)
        KEY_WAIT_FIRST: begin
          if (sfrWrData == KEY_FIRST) begin
            nxt_key = KEY_WAIT_SECOND;
          end
        end
        KEY_WAIT_SECOND: begin
          if (sfrWrData == KEY_SECOND) begin
            keyDone = 1'b1;
            nxt_key = KEY_WAIT_FIRST;
          end else if (sfrWrData == KEY_FIRST) begin
            nxt_key = KEY_WAIT_SECOND;
          end else begin
            nxt_key = KEY_WAIT_FIRST;
          end
        end
        default: begin
          nxt_key = KEY_WAIT_FIRST;
        end
      endcase
    end
    // A write elsewhere also breaks a partial key
    else if (sfrWr) begin
      nxt_key = KEY_WAIT_FIRST;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      key_ff <= KEY_WAIT_FIRST;
    end else begin
      key_ff <= nxt_key;
    end
  end

  // Timeout program register
  always_comb begin
    nxt_tsel = tsel_ff;
    if (progWrite) begin
      nxt_tsel = sfrWrData[TSEL_LSB +: TSEL_W];
    end
    // Own pulse acts as a chip reset
    if (state_ff == TMR_RST_PULSE) begin
      nxt_tsel = TSEL_RESET;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tsel_ff <= TSEL_RESET;
    end else begin
      tsel_ff <= nxt_tsel;
    end
  end

  // Read data; service register is write-only and reads zero
  always_comb begin
    nxt_rdData = rdData_ff;
    if (progRead) begin
      nxt_rdData = {PROG_RSVD_READ, tsel_ff};
    end else if (sfrRd) begin
      nxt_rdData = 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign sfrRdData = rdData_ff;

  // Supervision clock enable
  always_comb begin
    // Toggles from reset, held only in power-down, so the phase is known
    nxt_half = ~half_ff;
    if (powerDown) begin
      nxt_half = half_ff;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= nxt_half;
    end
  end

  always_comb begin
    if (doubleSpeedMode && !fixedClockSelect) begin
      superTick = 1'b1;
    end else begin
      superTick = half_ff;
    end
  end

  // Timer state
  always_comb begin
    nxt_state = state_ff;
    nxt_pulse = pulse_ff;
    chainClear = 1'b0;
    chainTick = 1'b0;
    nxt_pin = 1'b0;
    case (state_ff)
      TMR_DISABLED: begin
        chainClear = 1'b1;
        if (keyDone) begin
          nxt_state = TMR_RUNNING;
        end
      end
      TMR_RUNNING: begin
        chainClear = keyDone;
        chainTick = superTick && !powerDown;
        if (overflow) begin
          nxt_state = TMR_RST_PULSE;
          nxt_pulse = 7'h00;
          nxt_pin = 1'b1;
        end
      end
      TMR_RST_PULSE: begin
        chainClear = 1'b1;
        nxt_pin = 1'b1;
        nxt_pulse = pulse_ff + 7'h01;
        if (pulse_ff == RST_PULSE_LAST) begin
          nxt_pin = 1'b0;
          nxt_state = TMR_DISABLED;
        end
      end
      default: begin
        nxt_state = TMR_DISABLED;
        chainClear = 1'b1;
      end
    endcase
    // Registered so the status output is glitch free
    nxt_enabled = (nxt_state == TMR_RUNNING);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= TMR_DISABLED;
      pulse_ff <= 7'h00;
      pin_ff <= 1'b0;
      enabled_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pulse_ff <= nxt_pulse;
      pin_ff <= nxt_pin;
      enabled_ff <= nxt_enabled;
    end
  end

  sup_count_chain sup_count_chain_i (
    .core_clk(core_clk),
    .rst(rst),
    .clear(chainClear),
    .tick(chainTick),
    .timeoutSel(tsel_ff),
    .terminal(overflow),
    .prescalerVal(prescalerVal),
    .counterVal(counterVal)
  );

  // Idle has no effect on counting
  logic idleSeen;
  assign idleSeen = idleMode;

  assign rstPinOut = pin_ff;
  // Released whenever the pulse is not driven
  assign rstPinOeN = ~pin_ff;
  assign timerEnabled = enabled_ff && (idleSeen | ~idleSeen);
  assign counterValue = counterVal;

endmodule

// file: sim/sup_timer_assertions.sv
/*
  Port checker for the supervision timer.
  Bound to sup_supervision_timer and sees its ports only.
*/
module sup_timer_checker
  import sup_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register access
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  // Mode, reset pin and status
  input wire logic powerDown,
  input wire logic rstPinOut,
  input wire logic rstPinOeN,
  input wire logic timerEnabled,
  input wire logic [sup_pkg::COUNTER_W-1:0] counterValue
);
  logic [7:0] pulseCnt_ff, nxt_pulseCnt;
  logic keyFirst, keySecond;

  always_comb begin
    keyFirst = sfrWr && sfrAddr == SERVICE_KEY_ADDR && sfrWrData == KEY_FIRST;
    keySecond = sfrWr && sfrAddr == SERVICE_KEY_ADDR && sfrWrData == KEY_SECOND;
    nxt_pulseCnt = rstPinOut ? pulseCnt_ff + 8'h01 : 8'h00;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulseCnt_ff <= 8'h00;
    end else begin
      pulseCnt_ff <= nxt_pulseCnt;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_oe_low; rstPinOeN == !rstPinOut; endproperty
  a_oe_low: assert property (p_oe_low) else $error("pin enable mismatch");
  property p_pulse_len; $fell(rstPinOut) |-> pulseCnt_ff == 8'h60; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length");
  property p_pulse_cap; rstPinOut |-> pulseCnt_ff < 8'h60; endproperty
  a_pulse_cap: assert property (p_pulse_cap) else $error("pulse too long");
  property p_stop; $fell(rstPinOut) |-> !timerEnabled; endproperty
  a_stop: assert property (p_stop) else $error("enabled after pulse");
  property p_rise; $rose(rstPinOut) |-> $past(timerEnabled); endproperty
  a_rise: assert property (p_rise) else $error("pulse while disabled");
  property p_key;
    keySecond && $past(keyFirst) && !rstPinOut |=> timerEnabled && counterValue == 7'h00;
  endproperty
  a_key: assert property (p_key) else $error("key not taken");
  property p_hold; $fell(timerEnabled) |-> rstPinOut || $past(rstPinOut); endproperty
  a_hold: assert property (p_hold) else $error("timer stopped");
  property p_start; $rose(timerEnabled) |-> $past(keySecond); endproperty
  a_start: assert property (p_start) else $error("enable without key");
  property p_freeze; powerDown && !sfrWr |=> $stable(counterValue); endproperty
  a_freeze: assert property (p_freeze) else $error("count moved");
  property p_rd_key; sfrRd && sfrAddr == SERVICE_KEY_ADDR |=> sfrRdData == 8'h00; endproperty
  a_rd_key: assert property (p_rd_key) else $error("service read");
  property p_rd_rsvd;
    sfrRd && sfrAddr == TIMEOUT_PROG_ADDR |=> sfrRdData[7:3] == PROG_RSVD_READ;
  endproperty
  a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved bits");
endmodule

bind sup_supervision_timer sup_timer_checker sup_timer_checker_i (
  .core_clk(core_clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
  .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .powerDown(powerDown),
  .rstPinOut(rstPinOut), .rstPinOeN(rstPinOeN), .timerEnabled(timerEnabled),
  .counterValue(counterValue)
);

// file: sim/tb_sup_supervision_timer.sv
/*
  Self-checking bench for the supervision timer.
  Assumes the checker is bound; drives all inputs at the falling edge.
*/
module tb_sup_supervision_timer
  import sup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk, rst, sfrWr, sfrRd, doubleSpeedMode, fixedClockSelect, idleMode, powerDown;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, rdv;
  logic sfrHit, rstPinOut, rstPinOeN, timerEnabled;
  logic [COUNTER_W-1:0] counterValue;
  logic [7:0] brkA [2] = '{8'ha5, SERVICE_KEY_ADDR};
  logic [7:0] brkD [2] = '{KEY_SECOND, 8'h55};
  int n_fail = 0;
  int check_count = 0;
  int cnt, hi;

  sup_supervision_timer sup_supervision_timer_i (
    .core_clk(core_clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .sfrHit(sfrHit),
    .doubleSpeedMode(doubleSpeedMode), .fixedClockSelect(fixedClockSelect),
    .idleMode(idleMode), .powerDown(powerDown), .rstPinOut(rstPinOut),
    .rstPinOeN(rstPinOeN), .timerEnabled(timerEnabled), .counterValue(counterValue)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  // Called just after a falling edge; returns at one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrWr = 1'b1;
    sfrAddr = a;
    sfrWrData = d;
    @(negedge core_clk);
    sfrWr = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrRd = 1'b1;
    sfrAddr = a;
    @(negedge core_clk);
    d = sfrRdData;
    sfrRd = 1'b0;
    @(negedge core_clk);
  endtask

  // Both key bytes back to back
  task automatic key();
    sfrWr = 1'b1;
    sfrAddr = SERVICE_KEY_ADDR;
    sfrWrData = KEY_FIRST;
    @(negedge core_clk);
    sfrWrData = KEY_SECOND;
    @(negedge core_clk);
    sfrWr = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Overflow run alone is near 99k cycles
  initial begin
    #(104000 * 50);
    n_fail++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    doubleSpeedMode = 1'b1;
    fixedClockSelect = 1'b0;
    idleMode = 1'b0;
    powerDown = 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    chk(timerEnabled, 1'b0, "enabled out of reset");
    chk(rstPinOeN, 1'b1, "pin enable out of reset");
    rd(TIMEOUT_PROG_ADDR, rdv);
    chk(rdv, 8'h00, "program reset value");
    wr(TIMEOUT_PROG_ADDR, 8'h05);
    rd(TIMEOUT_PROG_ADDR, rdv);
    chk(rdv, 8'h05, "program readback");
    rd(8'h55, rdv);
    chk(rdv, 8'h00, "unmapped read");
    chk(sfrHit, 1'b0, "hit on unmapped address");
    rd(TIMEOUT_PROG_ADDR, rdv);
    chk(rdv, 8'h05, "program held");
    chk(sfrHit, 1'b1, "no hit on program register");
    rd(SERVICE_KEY_ADDR, rdv);
    chk(rdv, 8'h00, "service read");
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      wr(SERVICE_KEY_ADDR, KEY_FIRST);
      wr(brkA[i], brkD[i]);
      wr(SERVICE_KEY_ADDR, KEY_SECOND);
      chk(timerEnabled, 1'b0, "broken key enabled");
    end
    wr(SERVICE_KEY_ADDR, KEY_FIRST);
    wr(SERVICE_KEY_ADDR, KEY_SECOND);
    chk(timerEnabled, 1'b1, "key not taken");
    chk(counterValue, 7'h00, "count after key");
    $display("test key done");
    powerDown = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    powerDown = 1'b0;
    chk(timerEnabled, 1'b0, "enabled after reset wake");
    rd(TIMEOUT_PROG_ADDR, rdv);
    chk(rdv, 8'h00, "program after reset");
    $display("test reset wake done");
    idleMode = 1'b1;
    key();
    repeat (500) @(negedge core_clk);
    wr(TIMEOUT_PROG_ADDR, 8'h00);
    wr(SERVICE_KEY_ADDR, 8'h00);
    chk(timerEnabled, 1'b1, "timer stopped by write");
    key();
    cnt = 0;
    // Stalls of 100 ticks each: power-down, fixed half rate, single speed
    while (rstPinOut !== 1'b1 && cnt < 100000) begin
      @(negedge core_clk);
      cnt++;
      powerDown = cnt >= 1000 && cnt < 1100;
      fixedClockSelect = cnt >= 2000 && cnt < 2200;
      doubleSpeedMode = !(cnt >= 3000 && cnt < 3200);
    end
    chk(cnt, 6 * 16383 + 300, "cycles to overflow");
    chk(counterValue, 7'h00, "count bits above prescaler");
    chk(rstPinOeN, 1'b0, "pin not driven in pulse");
    hi = 0;
    while (rstPinOut === 1'b1 && hi < 200) begin
      sfrWr = (hi == 1);
      sfrAddr = TIMEOUT_PROG_ADDR;
      sfrWrData = 8'h07;
      @(negedge core_clk);
      hi++;
    end
    chk(hi, 96, "pulse length");
    chk(timerEnabled, 1'b0, "enabled after overflow");
    rd(TIMEOUT_PROG_ADDR, rdv);
    chk(rdv, 8'h00, "program after overflow");
    $display("test overflow done");
    tally_and_finish();
  end
endmodule
